// *** design/serial_port_regs.vh ***
// Constants for the serial port with flow control.
// Assumes a 25 MHz system clock and an 8-bit character path.
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH
`define CLK_HZ 25000000
`define RATE_4800 3'h0
`define RATE_9600 3'h1
`define RATE_19200 3'h2
`define RATE_38400 3'h3
`define RATE_57600 3'h4
`define RATE_115200 3'h5
`define DIV_4800 16'h1457
`define DIV_9600 16'h0a2c
`define DIV_19200 16'h0516
`define DIV_38400 16'h028b
`define DIV_57600 16'h01b2
`define DIV_115200 16'h00d9
`define PAR_NONE 2'h0
`define PAR_ODD 2'h1
`define PAR_EVEN 2'h2
`define FLOW_NONE 3'h0
`define FLOW_XON 3'h1
`define FLOW_DSR 3'h2
`define FLOW_CTS 3'h3
`define FLOW_FULL 3'h4
`define CHAR_XOFF 8'h13
`define CHAR_XON 8'h11
`define RX_HIGH_MARK 8'h64
`define RX_LOW_MARK 8'h50
`define RX_DEPTH 128
`endif

// *** design/serial_tx.v ***
// Serial transmitter: start, 8 data bits LSB first, optional parity, one stop.
// Assumes div is stable while a frame is in flight.
`timescale 1ns/1ps
`include "serial_port_regs.vh"
module serial_tx (
    input wire clk,
    input wire resetn,
    input wire [15:0] div,
    input wire [1:0] parity,
    input wire start,
    input wire [7:0] data,
    output reg busy,
    output reg txd
);
    reg [15:0] cnt_reg;
    reg [3:0] bit_reg;
    reg [10:0] shift_reg;
    reg [3:0] last_reg;
    wire par_bit = (parity == `PAR_ODD) ? ~(^data) : (^data);
    always @(posedge clk) begin
        if (!resetn) begin
            busy <= 1'b0;
            txd <= 1'b1;
            cnt_reg <= 16'h0000;
            bit_reg <= 4'h0;
            shift_reg <= 11'h7ff;
            last_reg <= 4'h9;
        end else if (!busy) begin
            txd <= 1'b1;
            if (start) begin
                // (RL13) frame build
                busy <= 1'b1;
                txd <= 1'b0;
                cnt_reg <= div;
                bit_reg <= 4'h0;
                if (parity == `PAR_NONE) begin
                    shift_reg <= {2'b11, 1'b1, data};
                    last_reg <= 4'h9;
                end else begin
                    shift_reg <= {2'b11, par_bit, data};
                    last_reg <= 4'ha;
                end
            end
        end else if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
        end else if (bit_reg == last_reg) begin
            busy <= 1'b0;
            txd <= 1'b1;
        end else begin
            txd <= shift_reg[0];
            shift_reg <= {1'b1, shift_reg[10:1]};
            bit_reg <= bit_reg + 4'h1;
            cnt_reg <= div;
        end
    end
endmodule

// *** design/serial_rx.v ***
// Serial receiver sampling each bit at its middle.
// Assumes the line idles high; parity errors are flagged, not dropped.
`timescale 1ns/1ps
`include "serial_port_regs.vh"
module serial_rx (
    input wire clk,
    input wire resetn,
    input wire [15:0] div,
    input wire [1:0] parity,
    input wire rxd,
    output reg valid,
    output reg [7:0] data,
    output reg par_err
);
    reg [15:0] cnt_reg;
    reg [3:0] bit_reg;
    reg active_reg;
    reg [8:0] sh_reg;
    wire [3:0] last = (parity == `PAR_NONE) ? 4'h9 : 4'ha;
    always @(posedge clk) begin
        if (!resetn) begin
            valid <= 1'b0;
            data <= 8'h00;
            par_err <= 1'b0;
            cnt_reg <= 16'h0000;
            bit_reg <= 4'h0;
            active_reg <= 1'b0;
            sh_reg <= 9'h000;
        end else begin
            valid <= 1'b0;
            if (!active_reg) begin
                if (!rxd) begin
                    active_reg <= 1'b1;
                    cnt_reg <= {1'b0, div[15:1]};
                    bit_reg <= 4'h0;
                end
            end else if (cnt_reg != 16'h0000) begin
                cnt_reg <= cnt_reg - 16'h0001;
            end else begin
                cnt_reg <= div;
                bit_reg <= bit_reg + 4'h1;
                if (bit_reg == 4'h0) begin
                    if (rxd) begin
                        active_reg <= 1'b0;
                    end
                end else if (bit_reg == last) begin
                    // (RL13) stop bit closes frame
                    active_reg <= 1'b0;
                    valid <= rxd;
                    data <= sh_reg[7:0];
                    if (parity == `PAR_NONE) begin
                        par_err <= 1'b0;
                    end else begin
                        par_err <= (^sh_reg) ^ (parity == `PAR_ODD);
                    end
                end else if (bit_reg == 4'h9) begin
                    sh_reg[8] <= rxd;
                end else begin
                    sh_reg <= {sh_reg[8], rxd, sh_reg[7:1]};
                end
            end
        end
    end
endmodule

// *** design/serial_port_flow_control.v ***
// Summary of operation
// (RL1) Six line rates from 4800 to 115200 baud are selectable and read back.
// (RL2) The line rate lives in a store that reset, preset and power loss do not touch.
// (RL3) Parity is none, odd or even, with none as the default.
// (RL4) The parity choice is kept in the same persistent store.
// (RL5) Flow control has five readable, writable choices.
// (RL6) The far party configures the same flow-control choice.
// (RL7) With no flow control the far party keeps to slow rates and short messages.
// (RL8) In pacing mode XOFF 13H stops transmission and XON 11H resumes it.
// (RL9) In DSR/DTR mode transmission runs only while DSR is asserted.
// (RL10) In DSR/DTR mode DTR drops near 100 buffered characters and returns later.
// (RL11) In CTS/RTS mode transmission runs only while CTS is asserted.
// (RL12) In CTS/RTS mode RTS drops near 100 buffered characters and returns later.
// (RL13) A frame is start, eight data bits LSB first, optional parity, one stop.
// (RL14) Full handshake needs both DSR and CTS and drives DTR and RTS together.
//
// Serial port top with flow control and a receive buffer.
// Persistent settings come from an outside store through a load strobe;
// this block holds a working copy that its own reset does not clear.
`timescale 1ns/1ps
`include "serial_port_regs.vh"
module serial_port_flow_control #(
    parameter DEPTH = `RX_DEPTH
) (
    input wire CLK,
    input wire RESETN,
    input wire CFG_WRITE,
    input wire [2:0] CFG_RATE,
    input wire [1:0] CFG_PARITY,
    input wire [2:0] CFG_FLOW,
    output reg [2:0] RATE_SEL,
    output reg [1:0] PARITY_SEL,
    output reg [2:0] FLOW_SEL,
    input wire TX_VALID,
    input wire [7:0] TX_DATA,
    output reg TX_READY,
    output reg RX_VALID,
    output reg [7:0] RX_DATA,
    output reg RX_PAR_ERR,
    input wire RX_READY,
    input wire RXD,
    output reg TXD,
    input wire DSR,
    input wire CTS,
    output reg DTR,
    output reg RTS,
    output reg TX_PAUSED
);
    localparam AW = 7;
    localparam ST_IDLE = 2'h0;
    localparam ST_LOAD = 2'h1;
    localparam ST_WAIT = 2'h2;

    reg [15:0] div;
    wire tx_busy;
    wire tx_line;
    wire rx_valid;
    wire [7:0] rx_byte;
    wire rx_perr;
    reg [1:0] state_reg;
    reg [7:0] hold_reg;
    reg xoff_reg;
    reg [8:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] rd_reg;
    reg [7:0] fill_reg;
    reg hold_rx_reg;
    reg tx_ok;
    reg [1:0] state_next;
    reg [7:0] hold_next;
    reg ready_next;
    reg [AW-1:0] wr_next;
    reg [AW-1:0] rd_next;
    reg [7:0] fill_next;
    reg load_out;
    reg dsr_mode;
    reg cts_mode;
    wire push;
    wire pop;

    // (RL1) rate divider select
    always @* begin
        case (RATE_SEL)
            `RATE_4800: div = `DIV_4800;
            `RATE_9600: div = `DIV_9600;
            `RATE_19200: div = `DIV_19200;
            `RATE_38400: div = `DIV_38400;
            `RATE_57600: div = `DIV_57600;
            default: div = `DIV_115200;
        endcase
    end

    // Settings are persistent: RESETN stands for a preset or factory reset
    // and must not change them, so only the write strobe updates them.
    // The initial values model what the store yields at first power-up.
    // (RL3) parity none by default
    initial begin
        RATE_SEL = `RATE_9600;
        PARITY_SEL = `PAR_NONE;
        FLOW_SEL = `FLOW_NONE;
    end
    // (RL2) persistent rate
    // (RL4) persistent parity
    // (RL5) flow mode store
    always @(posedge CLK) begin
        if (CFG_WRITE) begin
            if (CFG_RATE <= `RATE_115200) begin
                RATE_SEL <= CFG_RATE;
            end
            if (CFG_PARITY != 2'h3) begin
                PARITY_SEL <= CFG_PARITY;
            end
            if (CFG_FLOW <= `FLOW_FULL) begin
                FLOW_SEL <= CFG_FLOW;
            end
        end
    end

    // (RL9) DSR gating
    // (RL11) CTS gating
    // (RL14) both lines needed
    always @* begin
        dsr_mode = 1'b0;
        cts_mode = 1'b0;
        case (FLOW_SEL)
            `FLOW_DSR: begin
                dsr_mode = 1'b1;
            end
            `FLOW_CTS: begin
                cts_mode = 1'b1;
            end
            `FLOW_FULL: begin
                dsr_mode = 1'b1;
                cts_mode = 1'b1;
            end
            default: begin
                dsr_mode = 1'b0;
            end
        endcase
    end

    // The gates combine, so the full handshake mode waits for both lines.
    always @* begin
        tx_ok = 1'b1;
        if (FLOW_SEL == `FLOW_XON && xoff_reg) begin
            tx_ok = 1'b0;
        end
        if (dsr_mode && !DSR) begin
            tx_ok = 1'b0;
        end
        if (cts_mode && !CTS) begin
            tx_ok = 1'b0;
        end
    end

    serial_tx u_tx (
        .clk(CLK),
        .resetn(RESETN),
        .div(div),
        .parity(PARITY_SEL),
        .start(state_reg == ST_LOAD),
        .data(hold_reg),
        .busy(tx_busy),
        .txd(tx_line)
    );

    serial_rx u_rx (
        .clk(CLK),
        .resetn(RESETN),
        .div(div),
        .parity(PARITY_SEL),
        .rxd(RXD),
        .valid(rx_valid),
        .data(rx_byte),
        .par_err(rx_perr)
    );

    // A frame already on the line always finishes; pacing acts between characters.
    always @* begin
        state_next = state_reg;
        hold_next = hold_reg;
        ready_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (TX_VALID && tx_ok && !TX_READY) begin
                    hold_next = TX_DATA;
                    ready_next = 1'b1;
                    state_next = ST_LOAD;
                end
            end
            ST_LOAD: begin
                state_next = ST_WAIT;
            end
            ST_WAIT: begin
                if (!tx_busy) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge CLK) begin
        if (!RESETN) begin
            state_reg <= ST_IDLE;
            hold_reg <= 8'h00;
            TX_READY <= 1'b0;
            TXD <= 1'b1;
            TX_PAUSED <= 1'b0;
        end else begin
            state_reg <= state_next;
            hold_reg <= hold_next;
            TX_READY <= ready_next;
            TXD <= tx_line;
            TX_PAUSED <= ~tx_ok;
        end
    end

    // (RL8) XOFF stops, XON resumes
    always @(posedge CLK) begin
        if (!RESETN) begin
            xoff_reg <= 1'b0;
        end else if (FLOW_SEL != `FLOW_XON) begin
            xoff_reg <= 1'b0;
        end else if (rx_valid && rx_byte == `CHAR_XOFF) begin
            xoff_reg <= 1'b1;
        end else if (rx_valid && rx_byte == `CHAR_XON) begin
            xoff_reg <= 1'b0;
        end
    end

    // A character that meets a full buffer is lost; the far side must honour
    // DTR or RTS well before that point.
    // Pacing characters are consumed, not stored, while pacing mode is active.
    assign push = rx_valid && (fill_reg < DEPTH) &&
        !(FLOW_SEL == `FLOW_XON && (rx_byte == `CHAR_XOFF || rx_byte == `CHAR_XON));
    assign pop = RX_VALID && RX_READY;

    always @(posedge CLK) begin
        if (push) begin
            mem[wr_reg] <= {rx_perr, rx_byte};
        end
    end

    // The output register refills whenever it is empty or being popped,
    // so a stored character shows on RX_VALID two cycles after its push.
    always @* begin
        wr_next = wr_reg;
        rd_next = rd_reg;
        load_out = (pop || !RX_VALID) && fill_reg != 8'h00;
        if (push) begin
            wr_next = wr_reg + 1'b1;
        end
        if (load_out) begin
            rd_next = rd_reg + 1'b1;
        end
        fill_next = fill_reg + {7'h00, push} - {7'h00, load_out};
    end

    always @(posedge CLK) begin
        if (!RESETN) begin
            wr_reg <= {AW{1'b0}};
            rd_reg <= {AW{1'b0}};
            fill_reg <= 8'h00;
            RX_VALID <= 1'b0;
            RX_DATA <= 8'h00;
            RX_PAR_ERR <= 1'b0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            fill_reg <= fill_next;
            if (load_out) begin
                RX_VALID <= 1'b1;
                {RX_PAR_ERR, RX_DATA} <= mem[rd_reg];
            end else if (pop) begin
                RX_VALID <= 1'b0;
            end
        end
    end

    // Hysteresis keeps the handshake lines from chattering near the mark.
    always @(posedge CLK) begin
        if (!RESETN) begin
            hold_rx_reg <= 1'b0;
        end else if (fill_reg >= `RX_HIGH_MARK) begin
            hold_rx_reg <= 1'b1;
        end else if (fill_reg <= `RX_LOW_MARK) begin
            hold_rx_reg <= 1'b0;
        end
    end

    // (RL10) DTR from buffer fill
    // (RL12) RTS from buffer fill
    always @(posedge CLK) begin
        if (!RESETN) begin
            DTR <= 1'b1;
            RTS <= 1'b1;
        end else begin
            // Outside their modes the lines rest asserted so a watching host never stalls.
            DTR <= !(dsr_mode && hold_rx_reg);
            RTS <= !(cts_mode && hold_rx_reg);
        end
    end
endmodule

// *** tb/serial_port_props.sv ***
// Checker for the serial port top, watching its ports only.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "serial_port_regs.vh"
module serial_port_props (
    input wire CLK,
    input wire RESETN,
    input wire CFG_WRITE,
    input wire [2:0] CFG_RATE,
    input wire [1:0] CFG_PARITY,
    input wire [2:0] CFG_FLOW,
    input wire [2:0] RATE_SEL,
    input wire [1:0] PARITY_SEL,
    input wire [2:0] FLOW_SEL,
    input wire TX_READY,
    input wire TXD,
    input wire DSR,
    input wire CTS,
    input wire DTR,
    input wire RTS,
    input wire TX_PAUSED
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    property p_rate;
        CFG_WRITE && CFG_RATE <= `RATE_115200 |=> RATE_SEL == $past(CFG_RATE);
    endproperty
    a_rate: assert property (p_rate) else $error("rate not loaded");
    property p_par;
        CFG_WRITE && CFG_PARITY != 2'h3 |=> PARITY_SEL == $past(CFG_PARITY);
    endproperty
    a_par: assert property (p_par) else $error("parity not loaded");
    property p_flow;
        CFG_WRITE && CFG_FLOW <= `FLOW_FULL |=> FLOW_SEL == $past(CFG_FLOW);
    endproperty
    a_flow: assert property (p_flow) else $error("flow not loaded");
    property p_dsr;
        TX_READY && $past(FLOW_SEL) == `FLOW_DSR |-> $past(DSR);
    endproperty
    a_dsr: assert property (p_dsr) else $error("sent without DSR");
    property p_cts;
        TX_READY && $past(FLOW_SEL) == `FLOW_CTS |-> $past(CTS);
    endproperty
    a_cts: assert property (p_cts) else $error("sent without CTS");
    property p_full;
        TX_READY && $past(FLOW_SEL) == `FLOW_FULL |-> $past(DSR) && $past(CTS);
    endproperty
    a_full: assert property (p_full) else $error("sent without both");
    property p_pause;
        TX_READY |-> !TX_PAUSED;
    endproperty
    a_pause: assert property (p_pause) else $error("sent while paused");
    property p_dtr;
        FLOW_SEL == `FLOW_NONE && $past(FLOW_SEL) == `FLOW_NONE |-> DTR && RTS;
    endproperty
    a_dtr: assert property (p_dtr) else $error("handshake low unused");
    property p_start;
        TX_READY |=> !TX_READY ##[0:2] !TXD;
    endproperty
    a_start: assert property (p_start) else $error("no start bit");
    property p_bit;
        $fell(TXD) |-> !TXD [*8];
    endproperty
    a_bit: assert property (p_bit) else $error("bit too short");
    c_full: cover property (TX_READY && FLOW_SEL == `FLOW_FULL);
    c_pause: cover property (TX_PAUSED);
    c_cfg: cover property (CFG_WRITE && CFG_RATE > `RATE_115200);
endmodule
bind serial_port_flow_control serial_port_props chk_u (.*);

// *** tb/serial_host_model.sv ***
// Far-side host: frames bytes onto RXD and decodes frames from TXD.
// Assumes BIT clocks per bit and shares the port's parity setting.
`timescale 1ns/1ps
module serial_host_model #(
    parameter BIT = 218
) (
    input wire clk,
    input wire [1:0] par,
    input wire txd,
    output reg rxd
);
    reg [7:0] got;
    reg got_par;
    integer got_n = 0;
    integer j;
    initial rxd = 1'b1;
    task send(input [7:0] b, input flip);
        integer k;
        reg p;
        begin
            p = ^b ^ (par == 2'h1) ^ flip;
            for (k = 0; k < 11; k = k + 1) begin
                if (k != 9 || par != 2'h0) begin
                    rxd <= (k == 0) ? 1'b0 : (k < 9) ? b[k-1] : (k == 9) ? p : 1'b1;
                    repeat (BIT) @(posedge clk);
                end
            end
        end
    endtask
    always begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk);
        for (j = 0; j < 9; j = j + 1) begin
            repeat (BIT) @(posedge clk);
            if (j < 8)
                got[j] = txd;
            else
                got_par = txd;
        end
        if (par != 2'h0)
            repeat (BIT) @(posedge clk);
        got_n = got_n + 1;
    end
endmodule

// *** tb/serial_port_flow_control_tb.sv ***
// Self-checking bench for the serial port with flow control.
// Assumes the host model on the line side; traffic runs at 115200 baud.
`timescale 1ns/1ps
`include "serial_port_regs.vh"
module serial_port_flow_control_tb;
    reg CLK = 1'b0;
    reg RESETN = 1'b0;
    reg CFG_WRITE = 1'b0;
    reg TX_VALID = 1'b0;
    reg RX_READY = 1'b0;
    reg DSR = 1'b1;
    reg CTS = 1'b1;
    reg [2:0] CFG_RATE = 3'h0;
    reg [2:0] CFG_FLOW = 3'h0;
    reg [1:0] CFG_PARITY = 2'h0;
    reg [7:0] TX_DATA = 8'h00;
    wire [2:0] RATE_SEL;
    wire [2:0] FLOW_SEL;
    wire [1:0] PARITY_SEL;
    wire [7:0] RX_DATA;
    wire TX_READY, RX_VALID, RX_PAR_ERR, RXD, TXD, DTR, RTS, TX_PAUSED;
    integer failures = 0;
    integer compares = 0;
    integer i, m, n;
    reg [31:0] seed = 32'h679da8a3;
    reg [2:0] er, ep, ef;
    reg [7:0] b;
    serial_port_flow_control dut_u (.*);
    serial_host_model host_u (.clk(CLK), .par(PARITY_SEL), .txd(TXD), .rxd(RXD));
    initial forever #20 CLK = ~CLK;
    function [31:0] lfsr_next(input [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [2:0] keep(input [2:0] old, input [2:0] nw, input [2:0] top);
        keep = (nw > top) ? old : nw;
    endfunction
    task chk(input [8*6:1] name, input [7:0] exp, input [7:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("ERROR %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("compares %0d failures %0d", compares, failures);
            if (failures == 0 && compares > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task cfg(input [2:0] r, input [1:0] p, input [2:0] f);
        begin
            CFG_RATE <= r;
            CFG_PARITY <= p;
            CFG_FLOW <= f;
            CFG_WRITE <= 1'b1;
            @(posedge CLK);
            CFG_WRITE <= 1'b0;
            @(posedge CLK);
        end
    endtask
    task take(input [7:0] d, input integer lim);
        begin
            TX_DATA <= d;
            TX_VALID <= 1'b1;
            n = 0;
            @(posedge CLK);
            while (TX_READY !== 1'b1 && n < lim) begin
                n = n + 1;
                @(posedge CLK);
            end
            if (n < lim)
                TX_VALID <= 1'b0;
        end
    endtask
    task wait_host(input integer cnt);
        begin
            n = 0;
            while (host_u.got_n <= cnt && n < 3000) begin
                n = n + 1;
                @(posedge CLK);
            end
            chk("host", 8'h1, n < 3000);
            if (n >= 3000)
                tally_and_finish;
        end
    endtask
    task tx_one(input [1:0] p);
        begin
            seed = lfsr_next(seed);
            b = seed[7:0];
            m = host_u.got_n;
            take(b, 10);
            wait_host(m);
            chk("txbyte", b, host_u.got);
            if (p != 2'h0)
                chk("txpar", ^b ^ (p == 2'h1), host_u.got_par);
        end
    endtask
    initial begin
        repeat (2) @(posedge CLK);
        RESETN <= 1'b1;
        @(posedge CLK);
        chk("par", `PAR_NONE, PARITY_SEL);
        {er, ep, ef} = {RATE_SEL, 1'b0, PARITY_SEL, FLOW_SEL};
        for (i = 0; i < 8; i = i + 1) begin
            cfg(i[2:0], i[1:0], i[2:0]);
            er = keep(er, i[2:0], 3'h5);
            ep = keep(ep, {1'b0, i[1:0]}, 3'h2);
            ef = keep(ef, i[2:0], 3'h4);
            chk("rate", er, RATE_SEL);
            chk("par", ep, PARITY_SEL);
            chk("flow", ef, FLOW_SEL);
        end
        $display("test settings done");
        cfg(`RATE_115200, `PAR_EVEN, `FLOW_NONE);
        RESETN <= 1'b0;
        repeat (2) @(posedge CLK);
        RESETN <= 1'b1;
        @(posedge CLK);
        chk("rate", `RATE_115200, RATE_SEL);
        chk("par", `PAR_EVEN, PARITY_SEL);
        chk("dtr", 8'h1, DTR & RTS & TXD);
        $display("test persistence done");
        for (i = 0; i < 3; i = i + 1) begin
            // fast traffic runs with hardware pacing, never with flow control off
            cfg(`RATE_115200, i[1:0], `FLOW_CTS);
            tx_one(i[1:0]);
            for (m = 0; m < 2; m = m + 1) begin
                seed = lfsr_next(seed);
                host_u.send(seed[7:0], m[0] && i != 0);
                chk("rxbyte", seed[7:0], RX_DATA);
                chk("rxerr", m[0] && i != 0, RX_PAR_ERR);
                RX_READY <= 1'b1;
                @(posedge CLK);
                RX_READY <= 1'b0;
            end
        end
        $display("test frames done");
        for (i = 2; i < 5; i = i + 1) begin
            cfg(`RATE_115200, `PAR_NONE, i[2:0]);
            DSR <= (i != 2);
            CTS <= (i == 2);
            take(8'h5a, 1000);
            chk("hold", 8'h0, n < 1000);
            DSR <= 1'b1;
            CTS <= 1'b1;
            tx_one(`PAR_NONE);
        end
        $display("test handshake done");
        cfg(`RATE_115200, `PAR_NONE, `FLOW_XON);
        host_u.send(`CHAR_XOFF, 1'b0);
        take(8'ha5, 500);
        chk("hold", 8'h0, n < 500);
        chk("pause", 8'h1, TX_PAUSED);
        chk("eaten", 8'h0, RX_VALID);
        m = host_u.got_n;
        fork
            host_u.send(`CHAR_XON, 1'b0);
            take(8'ha5, 3000);
        join
        chk("resume", 8'h1, n < 3000);
        wait_host(m);
        chk("txbyte", 8'ha5, host_u.got);
        $display("test pacing done");
        tally_and_finish;
    end
    initial begin
        #4000000;
        failures = failures + 1;
        tally_and_finish;
    end
endmodule
